/* hw/misc_pkg.sv */
// Constants shared by the miscellaneous pin block and its sense filter.
// Assumes a single 20 MHz clock and a 5-bit addressed, 8-bit control bus.
package misc_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int RESET_MIN_NS = 160;
    localparam int RESET_SETTLE_NS = 960;
    localparam int SENSE_MIN_NS = 160;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_SETTLE_CYC = (RESET_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SENSE_MIN_CYC = (SENSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SENSE_CNT_W = 3;
    localparam logic [SENSE_CNT_W-1:0] SENSE_CNT_MAX = SENSE_CNT_W'(SENSE_MIN_CYC);
    localparam logic [SENSE_CNT_W-1:0] SENSE_CNT_ZERO = 3'h0;
    localparam logic [SENSE_CNT_W-1:0] SENSE_CNT_ONE = 3'h1;

    // ==========================================================
    // Control bus and register map
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int NUM_SENSE = 2;
    localparam logic [ADDR_W-1:0] REG_MODE = 5'h00;
    localparam logic [ADDR_W-1:0] REG_INT_COND = 5'h01;
    localparam logic [ADDR_W-1:0] REG_ICMR = 5'h02;
    localparam logic [ADDR_W-1:0] REG_USER = 5'h03;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

    // ==========================================================
    // Field positions
    localparam int MODE_RUN_BIT = 0;
    localparam int MODE_CASCADE_BIT = 1;
    localparam int MODE_CSTART_BIT = 2;
    localparam int INTC_PARITY_BIT = 0;
    localparam int INTC_SENSE_BIT = 1;
    localparam int USR_SENSE0_BIT = 0;
    localparam int USR_SENSE1_BIT = 1;
    localparam int USR_EN0_BIT = 2;
    localparam int USR_EN1_BIT = 3;
    localparam logic [DATA_W-1:0] MODE_WR_MASK = 8'h03;
    localparam logic [DATA_W-1:0] INTC_MASK = 8'h03;
    localparam logic [DATA_W-1:0] USR_EN_MASK = 8'h0c;
    localparam logic [DATA_W-1:0] USR_SENSE_MASK = 8'h03;

    // ==========================================================
    // Control bus cycle state
    typedef enum logic [0:0] {
        CB_IDLE = 1'b0,
        CB_HOLD = 1'b1
    } cbus_state_e;

endpackage

/* hw/sense_filter.sv */
// Synchroniser and minimum-width filter for one user sense input.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps

module sense_filter
    import misc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sense_in,
    output logic hit
);

    // ==========================================================
    // Synchroniser
    logic sync1_r;
    logic sync2_r;
    logic [SENSE_CNT_W-1:0] cnt_r;
    logic [SENSE_CNT_W-1:0] cnt_nxt;
    logic hit_r;
    logic hit_nxt;

    // ==========================================================
    // Width counter
    always_comb
    begin
        cnt_nxt = SENSE_CNT_ZERO;
        if (sync2_r)
        begin
            cnt_nxt = (cnt_r == SENSE_CNT_MAX) ? cnt_r : cnt_r + SENSE_CNT_ONE;
        end
        hit_nxt = (cnt_nxt == SENSE_CNT_MAX);
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            cnt_r <= SENSE_CNT_ZERO;
            hit_r <= 1'b0;
        end
        else
        begin
            sync1_r <= sense_in;
            sync2_r <= sync1_r;
            cnt_r <= cnt_nxt;
            hit_r <= hit_nxt;
        end
    end

    assign hit = hit_r;

    // ==========================================================
    // Checks
    sequence s_held_high;
        sync2_r [*4];
    endsequence

    property p_hit_needs_width;
        @(posedge clk) disable iff (!nrst)
        $rose(hit_r) |-> $past(sync2_r, 1) && $past(sync2_r, 2) && $past(sync2_r, 4);
    endproperty
    a_hit_needs_width: assert property (p_hit_needs_width)
        else $error("Sense hit without a long enough asserted input.");

    property p_held_gives_hit;
        @(posedge clk) disable iff (!nrst)
        s_held_high |=> hit_r;
    endproperty
    a_held_gives_hit: assert property (p_held_gives_hit)
        else $error("Sense input held long enough but no hit.");

endmodule  // sense_filter

/* hw/misc_pins.sv */
// Miscellaneous pin logic: reset, user sense and enable pins, cascade sync.
// Assumes all pin inputs are synchronous to clk except the sense inputs.
//
// What this block does
// - Active-low reset clears every internal register except the data, acknowledge and interrupt output-enable registers, which it sets high.
// - Reset clears mode bit zero, leaving the device stopped.
// - Sense input 0 held 160 ns sets user register bit 0.
// - Sense input 1 held 160 ns sets user register bit 1.
// - Sense bits stay set until cleared by a control bus write.
// - Enable output 0 follows user register bit two.
// - Enable output 1 follows its own user register enable bit.
// - Cascade ready is released once cascade mode is set and JK received.
// - Internal logic and pin latching run on the local byte clock.
// - Unmasked latched conditions pull the open-drain interrupt output low.
`timescale 1ns/1ps

module misc_pins
    import misc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce_n,
    input wire logic rd_not_wr,
    input wire logic [misc_pkg::ADDR_W-1:0] cba,
    input wire logic [misc_pkg::DATA_W-1:0] cbd_i,
    output logic [misc_pkg::DATA_W-1:0] cbd_o,
    output logic cbd_oe_n,
    input wire logic cbp_i,
    output logic cbp_o,
    output logic cbp_oe_n,
    input wire logic cbpe,
    output logic ack_o,
    output logic ack_oe_n,
    output logic int_o,
    output logic int_oe_n,
    input wire logic [misc_pkg::NUM_SENSE-1:0] user_sense,
    output logic user_out_0,
    output logic user_out_1,
    input wire logic cascade_start,
    input wire logic jk_pair_rx,
    output logic cascade_ready_o,
    output logic cascade_ready_oe_n
);

    // ==========================================================
    // Helpers
    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        is_reg = (a == off);
    endfunction

    // ==========================================================
    // Sense filters
    logic [NUM_SENSE-1:0] hit;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SENSE; gi++)
        begin : g_sense
            sense_filter u_filt (
                .clk(clk),
                .nrst(nrst),
                .sense_in(user_sense[gi]),
                .hit(hit[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Register and bus state
    cbus_state_e st_r;
    cbus_state_e st_nxt;
    logic [DATA_W-1:0] mode_r;
    logic [DATA_W-1:0] mode_nxt;
    logic [DATA_W-1:0] int_cond_r;
    logic [DATA_W-1:0] int_cond_nxt;
    logic [DATA_W-1:0] icmr_r;
    logic [DATA_W-1:0] icmr_nxt;
    logic [DATA_W-1:0] user_sense_enable_reg;
    logic [DATA_W-1:0] usr_nxt;
    logic [DATA_W-1:0] cbd_o_r;
    logic [DATA_W-1:0] cbd_o_nxt;
    logic [DATA_W-1:0] rdata;
    logic cbp_o_r;
    logic cbp_o_nxt;
    logic cbd_oe_n_r;
    logic cbd_oe_n_nxt;
    logic ack_oe_n_r;
    logic ack_oe_n_nxt;
    logic int_oe_n_r;
    logic int_oe_n_nxt;
    logic casc_rel_r;
    logic casc_rel_nxt;
    logic take;
    logic par_ok;
    logic do_wr;

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        take = (st_r == CB_IDLE) && !ce_n;
        par_ok = !cbpe || (^{cbp_i, cbd_i});
        do_wr = take && !rd_not_wr && par_ok;

        rdata = REG_RESET;
        if (is_reg(cba, REG_MODE))
        begin
            rdata = mode_r;
        end
        else if (is_reg(cba, REG_INT_COND))
        begin
            rdata = int_cond_r;
        end
        else if (is_reg(cba, REG_ICMR))
        begin
            rdata = icmr_r;
        end
        else if (is_reg(cba, REG_USER))
        begin
            rdata = user_sense_enable_reg;
        end

        // Writing zero to a sense bit clears it; a new hit in the same cycle wins.
        usr_nxt = user_sense_enable_reg;
        mode_nxt = mode_r;
        icmr_nxt = icmr_r;
        int_cond_nxt = int_cond_r;
        if (do_wr && is_reg(cba, REG_USER))
        begin
            usr_nxt = (user_sense_enable_reg & cbd_i & USR_SENSE_MASK)
                | (cbd_i & USR_EN_MASK);
        end
        usr_nxt[USR_SENSE0_BIT] = usr_nxt[USR_SENSE0_BIT] | hit[0];
        usr_nxt[USR_SENSE1_BIT] = usr_nxt[USR_SENSE1_BIT] | hit[1];
        if (do_wr && is_reg(cba, REG_MODE))
        begin
            mode_nxt = (mode_r & ~MODE_WR_MASK) | (cbd_i & MODE_WR_MASK);
        end
        if (do_wr && is_reg(cba, REG_ICMR))
        begin
            icmr_nxt = cbd_i & INTC_MASK;
        end
        if (do_wr && is_reg(cba, REG_INT_COND))
        begin
            int_cond_nxt = int_cond_r & cbd_i;
        end
        if (take && !rd_not_wr && !par_ok)
        begin
            int_cond_nxt[INTC_PARITY_BIT] = 1'b1;
        end
        if (|hit)
        begin
            int_cond_nxt[INTC_SENSE_BIT] = 1'b1;
        end

        // Cascade ready is released after a JK pair in cascade mode.
        casc_rel_nxt = mode_nxt[MODE_CASCADE_BIT] && (casc_rel_r || jk_pair_rx);
        mode_nxt[MODE_CSTART_BIT] = casc_rel_nxt
            && (mode_r[MODE_CSTART_BIT] || cascade_start);

        st_nxt = st_r;
        cbd_o_nxt = cbd_o_r;
        cbp_o_nxt = cbp_o_r;
        case (st_r)
            CB_IDLE:
            begin
                if (take)
                begin
                    st_nxt = CB_HOLD;
                    cbd_o_nxt = rdata;
                    cbp_o_nxt = ~^rdata;
                end
            end
            CB_HOLD:
            begin
                if (ce_n)
                begin
                    st_nxt = CB_IDLE;
                end
            end
            default:
            begin
                st_nxt = CB_IDLE;
            end
        endcase
        ack_oe_n_nxt = (st_nxt != CB_HOLD);
        cbd_oe_n_nxt = !((st_nxt == CB_HOLD) && rd_not_wr);
        int_oe_n_nxt = !(|(int_cond_nxt & icmr_nxt));
    end

    // ==========================================================
    // Registers, all on the local byte clock
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_r <= CB_IDLE;
            mode_r <= REG_RESET;
            int_cond_r <= REG_RESET;
            icmr_r <= REG_RESET;
            user_sense_enable_reg <= REG_RESET;
            cbd_o_r <= REG_RESET;
            cbp_o_r <= 1'b0;
            cbd_oe_n_r <= 1'b1;
            ack_oe_n_r <= 1'b1;
            int_oe_n_r <= 1'b1;
            casc_rel_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            int_cond_r <= int_cond_nxt;
            icmr_r <= icmr_nxt;
            user_sense_enable_reg <= usr_nxt;
            cbd_o_r <= cbd_o_nxt;
            cbp_o_r <= cbp_o_nxt;
            cbd_oe_n_r <= cbd_oe_n_nxt;
            ack_oe_n_r <= ack_oe_n_nxt;
            int_oe_n_r <= int_oe_n_nxt;
            casc_rel_r <= casc_rel_nxt;
        end
    end

    // Serial bit and byte clock domains live in the serial datapath, not here.

    // ==========================================================
    // Outputs; open-drain pins only ever drive low.
    assign cbd_o = cbd_o_r;
    assign cbd_oe_n = cbd_oe_n_r;
    assign cbp_o = cbp_o_r;
    assign cbp_oe_n = cbd_oe_n_r;
    assign ack_o = cbp_o_r & 1'b0;
    assign ack_oe_n = ack_oe_n_r;
    assign int_o = ack_o;
    assign int_oe_n = int_oe_n_r;
    assign user_out_0 = user_sense_enable_reg[USR_EN0_BIT];
    assign user_out_1 = user_sense_enable_reg[USR_EN1_BIT];
    assign cascade_ready_o = ack_o;
    assign cascade_ready_oe_n = casc_rel_r;

    // ==========================================================
    // Checks
    property p_reset_clears;
        @(posedge clk) !nrst |=> user_sense_enable_reg == REG_RESET && int_cond_r == REG_RESET
            && ack_oe_n_r && cascade_ready_oe_n == 1'b0;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("Registers not cleared by reset.");

    property p_reset_stops;
        @(posedge clk) !nrst |=> !mode_r[MODE_RUN_BIT];
    endproperty
    a_reset_stops: assert property (p_reset_stops)
        else $error("Run bit set after reset.");

    property p_sense0_set;
        @(posedge clk) disable iff (!nrst) hit[0] |=> user_sense_enable_reg[USR_SENSE0_BIT];
    endproperty
    a_sense0_set: assert property (p_sense0_set)
        else $error("Sense bit 0 not set by hit.");

    property p_sense1_set;
        @(posedge clk) disable iff (!nrst) hit[1] |=> user_sense_enable_reg[USR_SENSE1_BIT];
    endproperty
    a_sense1_set: assert property (p_sense1_set)
        else $error("Sense bit 1 not set by hit.");

    property p_sense_sticky;
        @(posedge clk) disable iff (!nrst)
        user_sense_enable_reg[USR_SENSE0_BIT] && !(do_wr && is_reg(cba, REG_USER))
            |=> user_sense_enable_reg[USR_SENSE0_BIT];
    endproperty
    a_sense_sticky: assert property (p_sense_sticky)
        else $error("Sense bit 0 lost without a bus write.");

    property p_en0_write;
        @(posedge clk) disable iff (!nrst)
        do_wr && is_reg(cba, REG_USER) |=> user_out_0 == $past(cbd_i[USR_EN0_BIT]);
    endproperty
    a_en0_write: assert property (p_en0_write)
        else $error("Enable output 0 does not follow the written bit.");

    property p_en1_write;
        @(posedge clk) disable iff (!nrst)
        do_wr && is_reg(cba, REG_USER) |=> user_out_1 == $past(cbd_i[USR_EN1_BIT]);
    endproperty
    a_en1_write: assert property (p_en1_write)
        else $error("Enable output 1 does not follow the written bit.");

    sequence s_mode_jk;
        mode_r[MODE_CASCADE_BIT] && jk_pair_rx && !(do_wr && is_reg(cba, REG_MODE));
    endsequence

    property p_cascade_release;
        @(posedge clk) disable iff (!nrst) s_mode_jk |=> cascade_ready_oe_n;
    endproperty
    a_cascade_release: assert property (p_cascade_release)
        else $error("Cascade ready not released after JK in cascade mode.");

    property p_int_unmasked;
        @(posedge clk) disable iff (!nrst) (|(int_cond_r & icmr_r)) |-> !int_oe_n;
    endproperty
    a_int_unmasked: assert property (p_int_unmasked)
        else $error("Unmasked condition without interrupt.");

    property p_ack_held;
        @(posedge clk) disable iff (!nrst) !ack_oe_n && !ce_n |=> !ack_oe_n;
    endproperty
    a_ack_held: assert property (p_ack_held)
        else $error("Acknowledge released while chip enable low.");

endmodule  // misc_pins

/* dv/cascade_peer.sv */
// Far-side model: one cascaded neighbour device and the cascade start logic.
// Assumes clk and nrst are shared with the block; the ready line has a pull-up.
`timescale 1ns/1ps

module cascade_peer
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic dut_ready_oe_n,
    input wire logic peer_released,
    output logic ready_line,
    output logic cascade_start
);
    // ==========
    // Wired ready line
    // Open drain with a pull-up, so the line is high only once every device lets go.
    assign ready_line = dut_ready_oe_n & peer_released;

    // ==========
    // Start logic
    initial cascade_start = 1'h0;

    always @(negedge clk)
    begin
        if (!nrst)
        begin
            cascade_start <= 1'h0;
        end
        else
        begin
            cascade_start <= ready_line;
        end
    end
endmodule // cascade_peer

/* dv/tb.sv */
// Self-checking bench for the miscellaneous pin block.
// Assumes the control bus handshake of the block and a 20 MHz clock.
`timescale 1ns/1ps

module tb;
    import misc_pkg::*;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic ce_n = 1'h1;
    logic rd_not_wr = 1'h1;
    logic [ADDR_W-1:0] cba = 5'h00;
    logic [DATA_W-1:0] cbd_i = 8'h00;
    logic cbp_i = 1'h0;
    logic cbpe = 1'h1;
    logic [NUM_SENSE-1:0] user_sense = 2'h0;
    logic jk_pair_rx = 1'h0;
    logic peer_released = 1'h0;
    logic [DATA_W-1:0] cbd_o;
    logic cbd_oe_n, cbp_o, cbp_oe_n, ack_o, ack_oe_n, int_o, int_oe_n;
    logic user_out_0, user_out_1, cascade_start, cascade_ready_o, cascade_ready_oe_n;
    logic ready_line;
    int n_errors = 0;
    int n_tests = 0;

    always #25 clk = ~clk;

    misc_pins i_misc_pins (.clk(clk), .nrst(nrst), .ce_n(ce_n), .rd_not_wr(rd_not_wr),
        .cba(cba), .cbd_i(cbd_i), .cbd_o(cbd_o), .cbd_oe_n(cbd_oe_n), .cbp_i(cbp_i),
        .cbp_o(cbp_o), .cbp_oe_n(cbp_oe_n), .cbpe(cbpe), .ack_o(ack_o), .ack_oe_n(ack_oe_n),
        .int_o(int_o), .int_oe_n(int_oe_n), .user_sense(user_sense),
        .user_out_0(user_out_0), .user_out_1(user_out_1), .cascade_start(cascade_start),
        .jk_pair_rx(jk_pair_rx), .cascade_ready_o(cascade_ready_o),
        .cascade_ready_oe_n(cascade_ready_oe_n));

    cascade_peer i_cascade_peer (.clk(clk), .nrst(nrst), .dut_ready_oe_n(cascade_ready_oe_n),
        .peer_released(peer_released), .ready_line(ready_line),
        .cascade_start(cascade_start));

    // ==========
    // Tasks
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cb_cycle(input logic rd, input logic [4:0] a, input logic [7:0] d,
                            input logic bad, output logic [7:0] q);
        int k;
        @(negedge clk);
        ce_n = 1'h0;
        rd_not_wr = rd;
        cba = a;
        cbd_i = d;
        cbp_i = (~^d) ^ bad;
        for (k = 0; k < 20 && ack_oe_n !== 1'h0; k++)
        begin
            @(negedge clk);
        end
        check("ack_oe_n", 8'h00, {7'h00, ack_oe_n});
        check("ack_o", 8'h00, {7'h00, ack_o});
        q = cbd_o;
        if (rd)
        begin
            check("cbd_oe_n", 8'h00, {7'h00, cbd_oe_n});
            check("cbp_oe_n", 8'h00, {7'h00, cbp_oe_n});
            check("cbp_o", {7'h00, ~^q}, {7'h00, cbp_o});
        end
        else
        begin
            check("cbd_oe_n write", 8'h01, {7'h00, cbd_oe_n});
        end
        // Keep chip enable low one more clock: acknowledge and data must stand.
        @(negedge clk);
        check("ack held", 8'h00, {7'h00, ack_oe_n});
        check("cbd_o held", q, cbd_o);
        ce_n = 1'h1;
        for (k = 0; k < 20 && ack_oe_n !== 1'h1; k++)
        begin
            @(negedge clk);
        end
        check("ack release", 8'h01, {7'h00, ack_oe_n});
    endtask

    task automatic cb_read(input logic [4:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        cb_cycle(1'h1, a, 8'h00, 1'h0, q);
        check(what, exp, q);
    endtask

    task automatic cb_write(input logic [4:0] a, input logic [7:0] d, input logic bad = 1'h0);
        logic [7:0] q;
        cb_cycle(1'h0, a, d, bad, q);
    endtask

    task automatic pulse(input int s, input int n);
        @(negedge clk);
        user_sense[s] = 1'h1;
        repeat (n) @(negedge clk);
        user_sense[s] = 1'h0;
        repeat (8) @(negedge clk);
    endtask

    task automatic jk_pulse;
        @(negedge clk);
        jk_pair_rx = 1'h1;
        @(negedge clk);
        jk_pair_rx = 1'h0;
        repeat (2) @(negedge clk);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========
    // Tests
    initial
    begin
        repeat (10) @(negedge clk);
        nrst = 1'h1;
        repeat (RESET_SETTLE_CYC) @(negedge clk);
        check("ready_line", 8'h00, {7'h00, ready_line});
        cb_read(REG_MODE, 8'h00, "mode");
        cb_read(REG_USER, 8'h00, "user");
        cb_read(REG_INT_COND, 8'h00, "int_cond");
        done("reset");
        for (int i = 0; i < 4; i++)
        begin
            cb_write(REG_USER, {4'h0, 2'(i), 2'h0});
            check("user_out_0", {7'h00, i[0]}, {7'h00, user_out_0});
            check("user_out_1", {7'h00, i[1]}, {7'h00, user_out_1});
        end
        done("enables");
        cb_write(REG_ICMR, 8'h02);
        for (int s = 0; s < NUM_SENSE; s++)
        begin
            pulse(s, SENSE_MIN_CYC - 1);
            check("int short", 8'h01, {7'h00, int_oe_n});
            cb_read(REG_USER, 8'h0c, "user short");
            pulse(s, SENSE_MIN_CYC);
            check("int_oe_n", 8'h00, {7'h00, int_oe_n});
            check("int_o", 8'h00, {7'h00, int_o});
            cb_write(REG_USER, 8'h0c, 1'h1);
            cb_read(REG_USER, 8'h0c | (8'h01 << s), "user sensed");
            cb_write(REG_USER, 8'h0c);
            cb_read(REG_USER, 8'h0c, "user cleared");
            cb_read(REG_INT_COND, 8'h03, "int_cond");
            cb_write(REG_INT_COND, 8'h00);
            check("int cleared", 8'h01, {7'h00, int_oe_n});
        end
        cb_read(5'h1f, 8'h00, "unmapped");
        done("sense");
        jk_pulse();
        check("ready early", 8'h00, {7'h00, cascade_ready_oe_n});
        cb_write(REG_MODE, 8'h02);
        check("ready no jk", 8'h00, {7'h00, cascade_ready_oe_n});
        jk_pulse();
        check("ready released", 8'h01, {7'h00, cascade_ready_oe_n});
        check("cascade_ready_o", 8'h00, {7'h00, cascade_ready_o});
        check("start held", 8'h00, {7'h00, cascade_start});
        peer_released = 1'h1;
        repeat (4) @(negedge clk);
        cb_read(REG_MODE, 8'h06, "mode started");
        done("cascade");
        cb_write(REG_MODE, 8'h03);
        nrst = 1'h0;
        repeat (RESET_MIN_CYC) @(negedge clk);
        nrst = 1'h1;
        check("user_out_0", 8'h00, {7'h00, user_out_0});
        check("ready reset", 8'h00, {7'h00, cascade_ready_oe_n});
        repeat (RESET_SETTLE_CYC) @(negedge clk);
        cb_read(REG_MODE, 8'h00, "mode again");
        cb_read(REG_USER, 8'h00, "user again");
        done("second reset");
        results();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        results();
    end
endmodule // tb
